//--- common/drc_pkg.sv
// ****************************************************************
// debug run-control constants
// ****************************************************************
package drc_pkg;

  // apb address width and register offsets (byte addresses)
  localparam int unsigned DRC_AW       = 8;
  localparam logic [7:0]  DRC_OFS_CTRL = 8'h00;  // control, read/write
  localparam logic [7:0]  DRC_OFS_STAT = 8'h04;  // live state, read only
  localparam logic [7:0]  DRC_OFS_IST  = 8'h08;  // sticky events, read only
  localparam logic [7:0]  DRC_OFS_ICLR = 8'h0C;  // event clear, write only
  localparam logic [7:0]  DRC_OFS_IEN  = 8'h10;  // event enable
  localparam logic [7:0]  DRC_OFS_TCFG = 8'h14;  // delay-stop message count
  localparam logic [7:0]  DRC_OFS_PADR = 8'h18;  // point trace address
  localparam logic [7:0]  DRC_OFS_CMD  = 8'h1C;  // one-shot commands

  // control bits
  localparam int unsigned DRC_C_STEP   = 0;  // resume into single step
  localparam int unsigned DRC_C_RTPRI  = 1;  // trace favours realtime
  localparam int unsigned DRC_C_FSTOP  = 2;  // stop on trace memory full
  localparam int unsigned DRC_C_DSTOP  = 3;  // stop n messages after event
  localparam int unsigned DRC_C_TREN   = 4;  // trace enable
  localparam int unsigned DRC_C_PTEN   = 5;  // point trace on address
  localparam int unsigned DRC_C_PTRD   = 6;  // point trace read accesses
  localparam int unsigned DRC_C_PTWR   = 7;  // point trace write accesses
  localparam int unsigned DRC_C_SECEN  = 8;  // section trace enable
  localparam logic [31:0] DRC_CTRL_RST = 32'h0000_0002;

  // command bits
  localparam int unsigned DRC_K_BRK    = 0;  // forced break
  localparam int unsigned DRC_K_RES    = 1;  // resume execution
  localparam int unsigned DRC_K_RST    = 2;  // debugger cpu reset
  localparam int unsigned DRC_K_TRST   = 3;  // restart trace, clear loss

  // event bits
  localparam int unsigned DRC_NEV      = 4;
  localparam int unsigned DRC_E_BRK    = 0;  // break state entered
  localparam int unsigned DRC_E_LOSS   = 1;  // trace message dropped
  localparam int unsigned DRC_E_URST   = 2;  // user reset blocked
  localparam int unsigned DRC_E_TSTOP  = 3;  // trace stopped

  // interrupt kinds: maskable, fast exception, float exception
  localparam int unsigned DRC_NIRQ     = 3;
  localparam logic [1:0]  DRC_K_DATA   = 2'h1;  // data access message
  localparam logic [1:0]  DRC_K_FETCH  = 2'h2;  // section start fetch
  localparam logic        DRC_LINK_4P  = 1'b1;  // serial link mode only

  typedef enum logic [1:0] {
    DRC_RUN   = 2'b00,
    DRC_BREAK = 2'b01,
    DRC_STEP  = 2'b10,
    DRC_HALT  = 2'b11
  } drc_run_t;

endpackage

//--- rtl/drc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// two flop synchroniser for an active low pin, idles high
// ****************************************************************
module drc_sync
  import drc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic pin_n,
  output logic      pin_n_s
);

  typedef struct packed {
    logic s1;  // first stage, read by s2 only
    logic s2;  // settled copy
  } drc_sync_t;

  drc_sync_t s_q;
  drc_sync_t s_d;

  // shift the pin through both stages
  always_comb
  begin
    s_d    = s_q;
    s_d.s1 = pin_n;
    s_d.s2 = s_q.s1;
  end

  // registers idle at the released level
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      s_q <= 2'h3;
    else
      s_q <= s_d;
  end

  assign pin_n_s = s_q.s2;

endmodule
`default_nettype wire

//--- rtl/drc_irq_hold.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// interrupt hold: latches requests, releases them when unmasked
// ****************************************************************
module drc_irq_hold
  import drc_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                mask,
  input  wire logic [DRC_NIRQ-1:0] req,
  input  wire logic [DRC_NIRQ-1:0] ack,
  output logic      [DRC_NIRQ-1:0] pend,
  output logic      [DRC_NIRQ-1:0] irq_out
);

  typedef struct packed {
    logic [DRC_NIRQ-1:0] pend;  // held requests
    logic [DRC_NIRQ-1:0] out;   // requests shown to the cpu
  } drc_hold_t;

  drc_hold_t s_q;
  drc_hold_t s_d;

  // a request in the ack cycle stays pending; masked ones wait
  always_comb
  begin
    s_d      = s_q;
    s_d.pend = (s_q.pend & ~ack) | req;                   // RULE5
    s_d.out  = mask ? '0 : s_d.pend;                      // RULE4
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pend    = s_q.pend;
  assign irq_out = s_q.out;

endmodule
`default_nettype wire

//--- rtl/drc_top.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE1 - stepping blocks user and program resets
// RULE2 - debugger reset always resets the cpu
// RULE3 - debugger reset leaves cpu in break
// RULE4 - stepping masks interrupt acceptance
// RULE5 - masked interrupt requests wait until unmasked
// RULE6 - break releases cpu from halt
// RULE7 - stepped halt breaks at next instruction
// RULE8 - only user-injected pseudo-errors reset via safety
// RULE9 - dropped trace messages raise a loss flag
// RULE10 - non-realtime trace disables both stop functions
// RULE11 - point trace ignores data values
// RULE12 - section start may trace preceding instruction
// RULE13 - stack push writes omitted from data trace
// RULE14 - resume before software reset may skip it
// RULE15 - target pin reset only while program runs
// RULE16 - target releases reset while probe attaches
// RULE17 - four-pin serial debug link only
// RULE18 - stepping masks lift on free running
module drc_top
  import drc_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [DRC_AW-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                cpu_retire,
  input  wire logic                cpu_fetch_valid,
  input  wire logic [31:0]         cpu_fetch_addr,
  input  wire logic                cpu_halt_instr,
  input  wire logic                cpu_swrst_instr,
  input  wire logic                user_rst_req,
  input  wire logic                tgt_rst_pin_n,
  input  wire logic [DRC_NIRQ-1:0] irq_req,
  input  wire logic [DRC_NIRQ-1:0] irq_ack,
  input  wire logic                err_inject,
  input  wire logic                err_by_dbg,
  input  wire logic                dacc_valid,
  input  wire logic                dacc_read,
  input  wire logic                dacc_stack,
  input  wire logic [31:0]         dacc_addr,
  input  wire logic [31:0]         dacc_data,
  input  wire logic                trace_event,
  input  wire logic                section_start,
  input  wire logic                tmem_full,
  input  wire logic                tsink_ready,
  output logic                     cpu_rst,
  output logic                     cpu_run,
  output logic [DRC_NIRQ-1:0]      irq_out,
  output logic                     ecm_rst,
  output logic                     trc_valid,
  output logic [1:0]               trc_kind,
  output logic [31:0]              trc_addr,
  output logic [31:0]              trc_data,
  output logic                     link_4pin,
  output logic                     irq
);

  // ****************************************************************
  // state record
  // ****************************************************************
  typedef struct packed {
    drc_run_t           st;        // run-control state
    logic [31:0]        ctrl;      // control register
    logic [7:0]         dly_n;     // delay-stop message count
    logic [31:0]        pt_addr;   // point trace address
    logic [DRC_NEV-1:0] ev;        // sticky events
    logic [DRC_NEV-1:0] ien;       // event enables
    logic [31:0]        prdata;    // read data
    logic               pready;    // access phase answer
    logic               pslverr;   // unmapped address
    logic               cpu_rst;   // cpu reset pulse
    logic               cpu_run;   // cpu allowed to execute
    logic               ecm_rst;   // safety reset
    logic               resumed;   // first instruction after resume
    logic               lost;      // trace loss flag
    logic               stopped;   // trace stopped
    logic               armed;     // delay stop counting
    logic [7:0]         dly_cnt;   // messages left before stop
    logic [31:0]        last_fetch;// last fetched address
    logic               trc_valid; // trace message held
    logic [1:0]         trc_kind;  // message kind
    logic [31:0]        trc_addr;  // message address
    logic [31:0]        trc_data;  // message data
    logic               irq;       // interrupt line
    logic               link4;     // link mode indicator
  } drc_state_t;

  drc_state_t s_q;
  drc_state_t s_d;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // address match for one register
  function automatic logic hit(input logic [DRC_AW-1:0] a,
                               input logic [DRC_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic                pin_n_s;   // synchronised target reset pin
  logic [DRC_NIRQ-1:0] pend;      // held interrupt requests
  logic                step_mask; // masks while stepping
  logic                setup;     // apb setup phase
  logic                wr;        // apb write taking effect
  logic                brk_cmd;   // forced break
  logic                res_cmd;   // resume
  logic                drst_cmd;  // debugger reset
  logic                trst_cmd;  // trace restart

  assign setup     = psel & ~penable;
  assign wr        = psel & penable & s_q.pready & pwrite;
  assign brk_cmd   = wr & hit(paddr, DRC_OFS_CMD) & pwdata[DRC_K_BRK];
  assign res_cmd   = wr & hit(paddr, DRC_OFS_CMD) & pwdata[DRC_K_RES];
  assign drst_cmd  = wr & hit(paddr, DRC_OFS_CMD) & pwdata[DRC_K_RST];
  assign trst_cmd  = wr & hit(paddr, DRC_OFS_CMD) & pwdata[DRC_K_TRST];
  // masks apply only in step, so they drop once running free
  assign step_mask = (s_q.st == DRC_STEP);                // RULE18

  // pin reset from the target is asynchronous to clk_sys
  drc_sync u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin_n   (tgt_rst_pin_n),
    .pin_n_s (pin_n_s)
  );

  // interrupt hold and mask toward the cpu
  drc_irq_hold u_hold (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .mask    (step_mask),
    .req     (irq_req),
    .ack     (irq_ack),
    .pend    (pend),
    .irq_out (irq_out)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic               user_rst;  // reset from user system or target pin
    logic               sw_ok;     // software reset honoured
    logic [DRC_NEV-1:0] ev_set;    // events this cycle
    logic               pt_hit;    // point trace qualifier
    logic               d_ok;      // data message wanted
    logic               f_ok;      // fetch message wanted
    logic               slot;      // output slot free
    logic               rt;        // realtime priority
    user_rst = 1'b0;
    sw_ok    = 1'b0;
    ev_set   = '0;
    pt_hit   = 1'b0;
    d_ok     = 1'b0;
    f_ok     = 1'b0;
    slot     = 1'b0;
    rt       = 1'b0;
    s_d      = s_q;

    // apb: answer in the access phase, zero wait states
    s_d.pready  = setup;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0000_0000;
    if (setup && !pwrite)
    begin
      if (hit(paddr, DRC_OFS_CTRL))
        s_d.prdata = s_q.ctrl;
      else if (hit(paddr, DRC_OFS_STAT))
        s_d.prdata = {24'h00_0000, s_q.link4, s_q.stopped, pend,
                      s_q.lost, s_q.st};
      else if (hit(paddr, DRC_OFS_IST))
        s_d.prdata = {28'h000_0000, s_q.ev};
      else if (hit(paddr, DRC_OFS_IEN))
        s_d.prdata = {28'h000_0000, s_q.ien};
      else if (hit(paddr, DRC_OFS_TCFG))
        s_d.prdata = {24'h00_0000, s_q.dly_n};
      else if (hit(paddr, DRC_OFS_PADR))
        s_d.prdata = s_q.pt_addr;
      else if (!hit(paddr, DRC_OFS_ICLR) && !hit(paddr, DRC_OFS_CMD))
        s_d.pslverr = 1'b1;
    end
    else if (setup)
    begin
      // unmapped write: refused, nothing stored
      s_d.pslverr = !(hit(paddr, DRC_OFS_CTRL) || hit(paddr, DRC_OFS_IEN)
                   || hit(paddr, DRC_OFS_TCFG) || hit(paddr, DRC_OFS_PADR)
                   || hit(paddr, DRC_OFS_ICLR) || hit(paddr, DRC_OFS_CMD)
                   || hit(paddr, DRC_OFS_STAT) || hit(paddr, DRC_OFS_IST));
    end

    // register writes at the access edge
    if (wr && hit(paddr, DRC_OFS_CTRL))
      s_d.ctrl = pwdata;
    if (wr && hit(paddr, DRC_OFS_IEN))
      s_d.ien = pwdata[DRC_NEV-1:0];
    if (wr && hit(paddr, DRC_OFS_TCFG))
      s_d.dly_n = pwdata[7:0];
    if (wr && hit(paddr, DRC_OFS_PADR))
      s_d.pt_addr = pwdata;
    if (wr && hit(paddr, DRC_OFS_ICLR))
      s_d.ev = s_q.ev & ~pwdata[DRC_NEV-1:0];

    // run control
    if (cpu_retire)
      s_d.resumed = 1'b0;
    unique case (s_q.st)
      DRC_RUN:
      begin
        if (brk_cmd)
          s_d.st = DRC_BREAK;
        else if (cpu_halt_instr)
          s_d.st = DRC_HALT;
      end
      DRC_HALT:
      begin
        // a break wakes the cpu out of halt
        if (brk_cmd)
          s_d.st = DRC_BREAK;                             // RULE6
      end
      DRC_STEP:
      begin
        // stepped halt never halts, it breaks after it
        if (cpu_halt_instr || cpu_retire || brk_cmd)
          s_d.st = DRC_BREAK;                             // RULE7
      end
      DRC_BREAK:
      begin
        if (res_cmd)
        begin
          s_d.st      = s_q.ctrl[DRC_C_STEP] ? DRC_STEP : DRC_RUN;
          s_d.resumed = 1'b1;
        end
      end
    endcase
    // debugger reset ends in break from every run-control state
    if (drst_cmd)
      s_d.st = DRC_BREAK;                                 // RULE3
    s_d.cpu_run = (s_d.st == DRC_RUN) || (s_d.st == DRC_STEP);
    if (s_d.st == DRC_BREAK && s_q.st != DRC_BREAK)
      ev_set[DRC_E_BRK] = 1'b1;

    // resets: the pin is assumed quiet outside free running
    user_rst = user_rst_req | ~pin_n_s;                   // RULE15 RULE16
    // software reset right after a resume is dropped
    sw_ok = cpu_swrst_instr & ~s_q.resumed;               // RULE14
    s_d.cpu_rst = drst_cmd                                // RULE2
                | (~step_mask & (user_rst | sw_ok));      // RULE1
    if (step_mask && (user_rst || cpu_swrst_instr))
      ev_set[DRC_E_URST] = 1'b1;
    // debugger-written pseudo-errors do not reach safety reset
    s_d.ecm_rst = err_inject & ~err_by_dbg;               // RULE8

    // trace qualification
    rt     = s_q.ctrl[DRC_C_RTPRI];
    pt_hit = !s_q.ctrl[DRC_C_PTEN]
           || ((dacc_addr == s_q.pt_addr)                 // RULE11
               && (dacc_read ? s_q.ctrl[DRC_C_PTRD]
                             : s_q.ctrl[DRC_C_PTWR]));
    d_ok   = s_q.ctrl[DRC_C_TREN] && !s_q.stopped && dacc_valid
           && !dacc_stack && pt_hit;                      // RULE13
    f_ok   = s_q.ctrl[DRC_C_TREN] && !s_q.stopped
           && s_q.ctrl[DRC_C_SECEN] && section_start;
    slot   = !s_q.trc_valid || tsink_ready;
    if (trst_cmd)
    begin
      s_d.lost    = 1'b0;
      s_d.stopped = 1'b0;
      s_d.armed   = 1'b0;
    end
    if (s_q.trc_valid && tsink_ready)
      s_d.trc_valid = 1'b0;
    if ((d_ok || f_ok) && slot)
    begin
      s_d.trc_valid = 1'b1;
      if (d_ok)
      begin
        s_d.trc_kind = DRC_K_DATA;
        s_d.trc_addr = dacc_addr;
        s_d.trc_data = dacc_data;
      end
      else
      begin
        // section start reports the instruction before the trigger
        s_d.trc_kind = DRC_K_FETCH;
        s_d.trc_addr = s_q.last_fetch;                    // RULE12
        s_d.trc_data = cpu_fetch_addr;
      end
      if (s_q.armed && s_q.dly_cnt != 8'h00)
        s_d.dly_cnt = s_q.dly_cnt - 8'h01;
    end
    // busy slot or a second message in one cycle: dropped for good
    if (((d_ok || f_ok) && !slot) || (d_ok && f_ok))
    begin
      s_d.lost           = 1'b1;                          // RULE9
      ev_set[DRC_E_LOSS] = 1'b1;
    end
    if (cpu_fetch_valid)
      s_d.last_fetch = cpu_fetch_addr;

    // stop functions only with realtime priority
    if (rt && s_q.ctrl[DRC_C_FSTOP] && tmem_full && !s_q.stopped)
    begin
      s_d.stopped         = 1'b1;                         // RULE10
      ev_set[DRC_E_TSTOP] = 1'b1;
    end
    if (rt && s_q.ctrl[DRC_C_DSTOP] && trace_event && !s_q.armed)
    begin
      s_d.armed   = 1'b1;                                 // RULE10
      s_d.dly_cnt = s_q.dly_n;
    end
    if (rt && s_q.armed && s_q.dly_cnt == 8'h00 && !s_q.stopped)
    begin
      s_d.stopped         = 1'b1;
      s_d.armed           = 1'b0;
      ev_set[DRC_E_TSTOP] = 1'b1;
    end
    if (!rt)
      s_d.armed = 1'b0;

    // set wins over a clear in the same cycle
    s_d.ev    = s_d.ev | ev_set;
    s_d.irq   = |(s_d.ev & s_d.ien);
    s_d.link4 = DRC_LINK_4P;                              // RULE17
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q       <= '0;
      s_q.st    <= DRC_RUN;
      s_q.ctrl  <= DRC_CTRL_RST;
      s_q.link4 <= DRC_LINK_4P;
    end
    else
      s_q <= s_d;
  end

  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign cpu_rst   = s_q.cpu_rst;
  assign cpu_run   = s_q.cpu_run;
  assign ecm_rst   = s_q.ecm_rst;
  assign trc_valid = s_q.trc_valid;
  assign trc_kind  = s_q.trc_kind;
  assign trc_addr  = s_q.trc_addr;
  assign trc_data  = s_q.trc_data;
  assign link_4pin = s_q.link4;
  assign irq       = s_q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic d_ok_w;  // data message wanted, for the loss check
  assign d_ok_w = s_q.ctrl[DRC_C_TREN] && !s_q.stopped && dacc_valid
                && !dacc_stack && !s_q.ctrl[DRC_C_PTEN];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_step_rst_block: assert property ( // RULE1
    (s_q.st == DRC_STEP && !drst_cmd) |=> !cpu_rst)
    else $error("reset passed during single step");
  a_dbg_rst_taken: assert property ( // RULE2
    drst_cmd |=> cpu_rst)
    else $error("debugger reset not applied");
  a_rst_to_break: assert property ( // RULE3
    drst_cmd |=> (s_q.st == DRC_BREAK) && !cpu_run)
    else $error("no break after debugger reset");
  a_step_irq_mask: assert property ( // RULE4
    (s_q.st == DRC_STEP) |=> (irq_out == 3'h0))
    else $error("interrupt reached cpu while stepping");
  a_irq_pend_hold: assert property ( // RULE5
    (step_mask && irq_req[0] && !irq_ack[0]) |=> pend[0])
    else $error("masked interrupt request lost");
  a_halt_break: assert property ( // RULE6
    (s_q.st == DRC_HALT && brk_cmd) |=> (s_q.st == DRC_BREAK))
    else $error("break did not leave halt");
  a_step_no_halt: assert property ( // RULE7
    (s_q.st == DRC_STEP && cpu_halt_instr) |=> (s_q.st == DRC_BREAK))
    else $error("stepped halt entered halt state");
  a_ecm_dbg_inj: assert property ( // RULE8
    (err_inject && err_by_dbg) |=> !ecm_rst)
    else $error("debugger pseudo-error caused safety reset");
  a_trace_loss: assert property ( // RULE9
    (d_ok_w && s_q.trc_valid && !tsink_ready) |=> s_q.lost)
    else $error("dropped trace message not flagged");
  a_nrt_nostop: assert property ( // RULE10
    (!s_q.ctrl[DRC_C_RTPRI] && !s_q.stopped) |=> !s_q.stopped)
    else $error("trace stopped without realtime priority");
  a_unmask_run: assert property ( // RULE18
    (s_q.st == DRC_RUN && pend[0] && !irq_ack[0]) |=> irq_out[0])
    else $error("pending interrupt not released when running");

endmodule
`default_nettype wire

//--- verification/drc_probe.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// probe model: drives the register port as an apb master
// ****************************************************************
module drc_probe
  import drc_pkg::*;
(
  input  wire logic              clk_sys,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [DRC_AW-1:0] paddr,
  output logic      [31:0]       pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  // idle bus until the first transfer
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // one transfer: held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import drc_pkg::*;
;
  // ****************************************************************
  // bench signals, all inputs but rstn idle at time zero, rstn held low
  // ****************************************************************
  logic clk_sys = 1'b0, rstn = 1'b0, tgt_rst_pin_n = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, trc_addr, trc_data, rd;
  logic cpu_retire = 0, cpu_fetch_valid = 0, cpu_halt_instr = 0;
  logic cpu_swrst_instr = 0, user_rst_req = 0, err_inject = 0;
  logic err_by_dbg = 0, dacc_valid = 0, dacc_read = 0, dacc_stack = 0;
  logic trace_event = 0, section_start = 0, tmem_full = 0;
  logic tsink_ready = 0;
  logic [31:0] cpu_fetch_addr = '0, dacc_addr = '0, dacc_data = '0;
  logic [2:0] irq_req = '0, irq_ack = '0, irq_out;
  logic cpu_rst, cpu_run, ecm_rst, trc_valid, link_4pin, irq;
  logic [1:0] trc_kind;
  int err_total = 0, comparisons = 0;
  logic [31:0] n;
  drc_top   drc_top_i   (.*);
  drc_probe drc_probe_i (.*);
  always #20 clk_sys = ~clk_sys;
  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    drc_probe_i.xfer(1'b1, a, d, rd, se);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    drc_probe_i.xfer(1'b0, a, 32'h0, rd, se);
    chk(rd & m, e);
  endtask
  task automatic wait_n(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    rc(DRC_OFS_CTRL, 32'hFFFFFFFF, DRC_CTRL_RST);
    rc(DRC_OFS_STAT, 32'hFF, 32'h80);
    chk(link_4pin, 1'b1);
    drc_probe_i.xfer(1'b0, 8'h20, 32'h0, rd, se);
    chk(se, 1'b1);
    $display("regs done");
  endtask
  task automatic t_step;
    wr(DRC_OFS_IEN, 32'h4);
    wr(DRC_OFS_CTRL, 32'h3);
    wr(DRC_OFS_CMD, 32'h1);
    wr(DRC_OFS_CMD, 32'h2);
    @(posedge clk_sys);
    user_rst_req <= 1'b1;
    irq_req      <= 3'h1;
    @(posedge clk_sys);
    irq_req <= 3'h0;
    wait_n(4);
    chk(cpu_rst, 1'b0);
    chk(irq_out, 3'h0);
    rc(DRC_OFS_STAT, 32'h3B, 32'h0A);
    rc(DRC_OFS_IST, 32'h4, 32'h4);
    chk(irq, 1'b1);
    user_rst_req   <= 1'b0;
    cpu_halt_instr <= 1'b1;
    cpu_retire     <= 1'b1;
    @(posedge clk_sys);
    {cpu_halt_instr, cpu_retire} <= 2'b00;
    wr(DRC_OFS_ICLR, 32'h4);
    wait_n(2);
    chk(irq, 1'b0);
    rc(DRC_OFS_STAT, 32'h3, 32'h1);
    wr(DRC_OFS_CTRL, 32'h2);
    wr(DRC_OFS_CMD, 32'h2);
    wait_n(3);
    chk(irq_out, 3'h1);
    chk(cpu_run, 1'b1);
    @(posedge clk_sys);
    irq_ack <= 3'h1;
    @(posedge clk_sys);
    irq_ack <= 3'h0;
    $display("step done");
  endtask
  task automatic t_rst;
    wr(DRC_OFS_CTRL, 32'h3);
    wr(DRC_OFS_CMD, 32'h1);
    wr(DRC_OFS_CMD, 32'h2);
    wr(DRC_OFS_CMD, 32'h4);
    #1;
    chk(cpu_rst, 1'b1);
    chk(cpu_run, 1'b0);
    rc(DRC_OFS_STAT, 32'h3, 32'h1);
    $display("debugger reset done");
  endtask
  task automatic t_halt;
    wr(DRC_OFS_CTRL, 32'h2);
    wr(DRC_OFS_CMD, 32'h2);
    @(posedge clk_sys);
    cpu_halt_instr <= 1'b1;
    @(posedge clk_sys);
    cpu_halt_instr <= 1'b0;
    rc(DRC_OFS_STAT, 32'h3, 32'h3);
    wr(DRC_OFS_CMD, 32'h1);
    rc(DRC_OFS_STAT, 32'h3, 32'h1);
    $display("halt done");
  endtask
  task automatic t_ecm(input logic dbg, input int e);
    @(posedge clk_sys);
    err_by_dbg <= dbg;
    err_inject <= 1'b1;
    @(posedge clk_sys);
    err_inject <= 1'b0;
    n = 0;
    repeat (4)
    begin
      #1 n += {31'h0, ecm_rst};
      @(posedge clk_sys);
    end
    chk(n, e);
    $display("pseudo error done");
  endtask
  task automatic t_trace;
    wr(DRC_OFS_CTRL, 32'h12);
    @(posedge clk_sys);
    dacc_valid <= 1'b1;
    dacc_addr  <= 32'h0000_0040;
    repeat (2) @(posedge clk_sys);
    dacc_valid <= 1'b0;
    rc(DRC_OFS_IST, 32'h2, 32'h2);
    chk(trc_valid, 1'b1);
    chk(trc_addr, 32'h0000_0040);
    chk(trc_kind, DRC_K_DATA);
    tsink_ready <= 1'b1;
    wait_n(2);
    chk(trc_valid, 1'b0);
    @(posedge clk_sys);
    {dacc_valid, dacc_stack} <= 2'b11;
    @(posedge clk_sys);
    {dacc_valid, dacc_stack} <= 2'b00;
    #1;
    chk(trc_valid, 1'b0);
    wr(DRC_OFS_CTRL, 32'h1C);
    tmem_full <= 1'b1;
    wait_n(4);
    rc(DRC_OFS_STAT, 32'h40, 32'h0);
    wr(DRC_OFS_CTRL, 32'h1E);
    wait_n(4);
    rc(DRC_OFS_STAT, 32'h40, 32'h40);
    tmem_full <= 1'b0;
    $display("trace done");
  endtask
  // ****************************************************************
  // verdict, watchdog and main sequence
  // ****************************************************************
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test;
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs;
    t_step;
    t_rst;
    t_halt;
    t_ecm(1'b1, 0);
    t_ecm(1'b0, 1);
    t_trace;
    finish_test;
  end
endmodule
`default_nettype wire
